/* logic/icec_defs.svh */
// Offsets, fields, reset values and timing counts of the input capture control block
// Behaviour
// R1: Per-channel enable bits at 6,5,4.
// R2: Selected edge sets flag bits 2,1,0.
// R3: Only software clears flags, by writing zero.
// R4: Edge code 00 fall, 01 rise, 10 both.
// R5: Edge fields 5:4,3:2,1:0; reset zero.
// R6: Filter enables at bits 6,5,4.
// R7: Synchronise inputs; disabled channel never flags.
`ifndef ICEC_DEFS_SVH
`define ICEC_DEFS_SVH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define ICEC_IDX_ENFLAG 8'h92
`define ICEC_IDX_EDGE   8'h93
`define ICEC_IDX_FILT   8'h94
`define ICEC_IDX_ISTAT  8'h98
`define ICEC_IDX_IMASK  8'h99
`define ICEC_ADR_ENFLAG {2'b00, `ICEC_IDX_ENFLAG, 2'b00}
`define ICEC_ADR_EDGE   {2'b00, `ICEC_IDX_EDGE, 2'b00}
`define ICEC_ADR_FILT   {2'b00, `ICEC_IDX_FILT, 2'b00}
`define ICEC_ADR_ISTAT  {2'b00, `ICEC_IDX_ISTAT, 2'b00}
`define ICEC_ADR_IMASK  {2'b00, `ICEC_IDX_IMASK, 2'b00}

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ICEC_EN_LSB   4
`define ICEC_FLAG_LSB 0
`define ICEC_FILT_LSB 4
`define ICEC_EDGE_W   2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ICEC_ENFLAG_RST 8'h00
`define ICEC_EDGE_RST   8'h00
`define ICEC_FILT_RST   8'h00
`define ICEC_ISTAT_RST  8'h00
`define ICEC_IMASK_RST  8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define ICEC_CLK_MHZ   125
`define ICEC_FILT_NS   32
`define ICEC_FILT_CYC  ((`ICEC_FILT_NS * `ICEC_CLK_MHZ + 999) / 1000)

`endif

/* logic/icec_pkg.sv */
// Types shared by the input capture control block
package icec_pkg;

	// Number of capture channels
	localparam int ICEC_NCH = 3;

	// Edge selection codes
	typedef enum logic [1:0] {
		ICEC_EDGE_FALL = 2'b00,
		ICEC_EDGE_RISE = 2'b01,
		ICEC_EDGE_BOTH = 2'b10,
		ICEC_EDGE_RSVD = 2'b11
	} icec_edge_t;

	// Wishbone request from the master
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [11:0] adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} icec_wb_req_t;

endpackage : icec_pkg

/* logic/icec_top.sv */
// Three-channel input capture edge control with Wishbone registers
`timescale 1ns/1ps
`include "icec_defs.svh"

module icec_top (
	input  wire logic                  clk_i,
	input  wire logic                  rst_n_i,
	input  wire logic                  ce_i,
	input  wire icec_pkg::icec_wb_req_t wb_req_i,
	output logic [31:0]                wb_dat_o,
	output logic                       wb_ack_o,
	input  wire logic [2:0]            cap_pin_i,
	output logic [2:0]                 cap_event_o,
	output logic                       irq_o
);
	import icec_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	localparam logic [2:0] FILT_LAST =
		3'(`ICEC_FILT_CYC - 1);

	// Reset images of the byte-wide registers
	localparam logic [7:0] ENFLAG_RST = `ICEC_ENFLAG_RST;
	localparam logic [7:0] EDGE_RST   = `ICEC_EDGE_RST;
	localparam logic [7:0] FILT_RST   = `ICEC_FILT_RST;
	localparam logic [7:0] ISTAT_RST  = `ICEC_ISTAT_RST;
	localparam logic [7:0] IMASK_RST  = `ICEC_IMASK_RST;

	// Pin synchroniser
	logic [2:0] sync1_reg;
	logic [2:0] sync2_reg;

	// Software-visible state
	logic [2:0] enable_reg;
	logic [2:0] flag_reg;
	logic [2:0] flag_next;
	logic [5:0] edge_sel_reg;
	logic [2:0] filt_en_reg;
	logic [2:0] istat_reg;
	logic [2:0] istat_next;
	logic [2:0] imask_reg;

	// Bus slave and output register state
	logic        ack_reg;
	logic [31:0] rdat_reg;
	logic        irq_reg;
	logic [2:0]  event_reg;

	// Per-channel detector results
	logic [2:0] lvl;
	logic [2:0] rise;
	logic [2:0] fall;
	logic [2:0] hit;
	logic [2:0] evt;

	// Bus decode
	logic        access;
	logic        wr_stb;
	logic        hit_enflag;
	logic        hit_edge;
	logic        hit_filt;
	logic        hit_istat;
	logic        hit_imask;
	logic        mapped;
	logic [7:0]  wbyte;
	logic [7:0]  rbyte;
	logic        wr_enflag;
	logic        wr_edge;
	logic        wr_filt;
	logic        wr_istat;
	logic        wr_imask;

	// ----------------------------------------
	// Input synchroniser
	// ----------------------------------------

	// Two flops per pin before any use
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sync1_reg <= 3'h0;
			sync2_reg <= 3'h0;
		end else if (ce_i) begin
			sync1_reg <= cap_pin_i;       // see R7
			sync2_reg <= sync1_reg;       // see R7
		end
	end

	// ----------------------------------------
	// Per-channel filter and edge detector
	// ----------------------------------------
	for (genvar ch = 0; ch < ICEC_NCH; ch++) begin : g_chan
		logic [2:0]  filt_cnt_reg;
		logic        filt_lvl_reg;
		logic        prev_reg;
		icec_edge_t  mode;
		logic        chan_hit;

		// Filter: a change must last FILT_CYC cycles
		always_ff @(posedge clk_i) begin
			if (!rst_n_i) begin
				filt_cnt_reg <= 3'h0;
				filt_lvl_reg <= 1'b0;
			end else if (ce_i) begin
				if (sync2_reg[ch] == filt_lvl_reg) begin
					filt_cnt_reg <= 3'h0;
				end else if (filt_cnt_reg == FILT_LAST) begin
					filt_cnt_reg <= 3'h0;
					filt_lvl_reg <= sync2_reg[ch];
				end else begin
					filt_cnt_reg <= filt_cnt_reg + 3'h1;
				end
			end
		end

		// Filtered or direct level
		assign lvl[ch] = filt_en_reg[ch] ? filt_lvl_reg
			: sync2_reg[ch];                       // see R6

		// Previous level, tracked even when disabled
		always_ff @(posedge clk_i) begin
			if (!rst_n_i) begin
				prev_reg <= 1'b0;
			end else if (ce_i) begin
				prev_reg <= lvl[ch];
			end
		end

		// Edge terms
		assign rise[ch] = lvl[ch] & ~prev_reg;
		assign fall[ch] = ~lvl[ch] & prev_reg;

		// Edge code decode
		assign mode = icec_edge_t'(edge_sel_reg[2*ch +: 2]);

		// Reserved code never triggers
		always_comb begin
			unique case (mode)
				ICEC_EDGE_FALL: chan_hit = fall[ch];           // see R4
				ICEC_EDGE_RISE: chan_hit = rise[ch];           // see R4
				ICEC_EDGE_BOTH: chan_hit = rise[ch] | fall[ch]; // see R4
				ICEC_EDGE_RSVD: chan_hit = 1'b0;               // see R4
			endcase
		end
		assign hit[ch] = chan_hit;

		// Only enabled channels raise an event
		assign evt[ch] = hit[ch] & enable_reg[ch];   // see R1, see R7
	end

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------

	// One access per request, ack for one cycle
	assign access = wb_req_i.cyc & wb_req_i.stb;
	assign wr_stb = access & ~ack_reg & wb_req_i.we
		& wb_req_i.sel[0];
	assign wbyte = wb_req_i.dat[7:0];

	// Address match
	assign hit_enflag = (wb_req_i.adr == `ICEC_ADR_ENFLAG);
	assign hit_edge   = (wb_req_i.adr == `ICEC_ADR_EDGE);
	assign hit_filt   = (wb_req_i.adr == `ICEC_ADR_FILT);
	assign hit_istat  = (wb_req_i.adr == `ICEC_ADR_ISTAT);
	assign hit_imask  = (wb_req_i.adr == `ICEC_ADR_IMASK);
	assign mapped     = hit_enflag | hit_edge | hit_filt
		| hit_istat | hit_imask;

	// Per-register write strobes
	assign wr_enflag = wr_stb & hit_enflag;
	assign wr_edge   = wr_stb & hit_edge;
	assign wr_filt   = wr_stb & hit_filt;
	assign wr_istat  = wr_stb & hit_istat;
	assign wr_imask  = wr_stb & hit_imask;

	// ----------------------------------------
	// Enable and flag register
	// ----------------------------------------

	// Hardware only sets; writing zero clears; set wins
	always_comb begin
		flag_next = flag_reg;
		if (wr_enflag) begin
			flag_next = flag_reg
				& wbyte[`ICEC_FLAG_LSB +: 3];   // see R3
		end
		flag_next = flag_next | evt;        // see R2
	end

	// Enable bits, written by software only
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			enable_reg <= ENFLAG_RST[`ICEC_EN_LSB +: 3];
		end else if (ce_i) begin
			if (wr_enflag) begin
				enable_reg <= wbyte[`ICEC_EN_LSB +: 3]; // see R1
			end
		end
	end

	// Flags: hardware sets, software clears
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			flag_reg <= ENFLAG_RST[`ICEC_FLAG_LSB +: 3];
		end else if (ce_i) begin
			flag_reg <= flag_next;              // see R2, see R3
		end
	end

	// ----------------------------------------
	// Edge select register
	// ----------------------------------------

	// Three two-bit fields, resets to zero
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			edge_sel_reg <= EDGE_RST[5:0];         // see R5
		end else if (ce_i) begin
			if (wr_edge) begin
				edge_sel_reg <= wbyte[5:0];        // see R5
			end
		end
	end

	// ----------------------------------------
	// Filter enable register
	// ----------------------------------------

	// One filter enable per channel
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			filt_en_reg <= FILT_RST[`ICEC_FILT_LSB +: 3];
		end else if (ce_i) begin
			if (wr_filt) begin
				filt_en_reg <= wbyte[`ICEC_FILT_LSB +: 3]; // see R6
			end
		end
	end

	// ----------------------------------------
	// Interrupt status and mask
	// ----------------------------------------

	// Write one to clear; a new event wins
	always_comb begin
		istat_next = istat_reg;
		if (wr_istat) begin
			istat_next = istat_reg & ~wbyte[2:0];
		end
		istat_next = istat_next | evt;
	end

	// Sticky status bits
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			istat_reg <= ISTAT_RST[2:0];
		end else if (ce_i) begin
			istat_reg <= istat_next;
		end
	end

	// Mask register, one enables a bit
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			imask_reg <= IMASK_RST[2:0];
		end else if (ce_i) begin
			if (wr_imask) begin
				imask_reg <= wbyte[2:0];
			end
		end
	end

	// Level interrupt, registered
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			irq_reg <= 1'b0;
		end else if (ce_i) begin
			irq_reg <= |(istat_reg & imask_reg);
		end
	end

	// Event pulses, one cycle each
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			event_reg <= 3'h0;
		end else if (ce_i) begin
			event_reg <= evt;
		end
	end

	// ----------------------------------------
	// Read mux and acknowledge
	// ----------------------------------------

	// Reserved bits and unmapped reads give zero
	always_comb begin
		rbyte = 8'h00;
		if (hit_enflag) begin
			rbyte[`ICEC_EN_LSB +: 3]   = enable_reg;
			rbyte[`ICEC_FLAG_LSB +: 3] = flag_reg;
		end else if (hit_edge) begin
			rbyte[5:0] = edge_sel_reg;
		end else if (hit_filt) begin
			rbyte[`ICEC_FILT_LSB +: 3] = filt_en_reg;
		end else if (hit_istat) begin
			rbyte[2:0] = istat_reg;
		end else if (hit_imask) begin
			rbyte[2:0] = imask_reg;
		end
	end

	// Ack one cycle after request, then drop
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ack_reg <= 1'b0;
		end else if (ce_i) begin
			ack_reg <= access & ~ack_reg;
		end
	end

	// Read data captured at the taking edge
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rdat_reg <= 32'h0000_0000;
		end else if (ce_i) begin
			if (access && !ack_reg) begin
				rdat_reg <= mapped ? {24'h00_0000, rbyte}
					: 32'h0000_0000;
			end
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------

	// Registered state straight to the ports
	assign wb_ack_o    = ack_reg;
	assign wb_dat_o    = rdat_reg;
	assign irq_o       = irq_reg;
	assign cap_event_o = event_reg;

endmodule // icec_top

/* dv/icec_pin_model.sv */
// Capture pin source driven from the bench
`timescale 1ns/1ps
module icec_pin_model (
	input  wire logic       clk_i,
	input  wire logic [2:0] lvl_i,
	output logic      [2:0] pin_o = 3'b000
);
	// Pins change just after an edge
	always @(posedge clk_i) begin
		pin_o <= lvl_i;
	end
endmodule // icec_pin_model

/* dv/icec_checker.sv */
// Port assertions of the input capture control block
`timescale 1ns/1ps
`include "icec_defs.svh"
module icec_checker (
	input wire logic                   clk_i,
	input wire logic                   rst_n_i,
	input wire logic                   ce_i,
	input wire icec_pkg::icec_wb_req_t wb_req_i,
	input wire logic [31:0]            wb_dat_o,
	input wire logic                   wb_ack_o,
	input wire logic [2:0]             cap_pin_i,
	input wire logic [2:0]             cap_event_o,
	input wire logic                   irq_o
);
	import icec_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// Taken requests
	wire logic go = wb_req_i.cyc && wb_req_i.stb && ce_i && !wb_ack_o;
	wire logic wgo = go && wb_req_i.we;
	wire logic rd_un = go && !wb_req_i.we && !(wb_req_i.adr inside {`ICEC_ADR_ENFLAG, `ICEC_ADR_EDGE,
		`ICEC_ADR_FILT, `ICEC_ADR_ISTAT, `ICEC_ADR_IMASK});
	ack_answer_a: assert property (go |=> wb_ack_o) else $error("no ack after request");
	ack_pulse_a: assert property (wb_ack_o && ce_i |=> !wb_ack_o) else $error("ack too long");
	ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(go)) else $error("ack without request");
	dat_upper_a: assert property (wb_dat_o[31:8] == 24'h0) else $error("upper data set");
	unmapped_zero_a: assert property (wb_ack_o && $past(rd_un) |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	event_quiet_a: assert property (($stable(cap_pin_i) && !wb_req_i.cyc && ce_i) [*8]
		|=> cap_event_o == 3'h0) else $error("event without pin change");
	irq_hold_a: assert property (irq_o && !(wb_req_i.cyc && wb_req_i.we) |=> irq_o)
		else $error("irq dropped without write");
	irq_cause_a: assert property ($rose(irq_o) |-> $past(cap_event_o) != 3'h0 || $past(wgo, 2))
		else $error("irq without event");
endmodule // icec_checker
bind icec_top icec_checker i_icec_checker (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
	.wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cap_pin_i(cap_pin_i),
	.cap_event_o(cap_event_o), .irq_o(irq_o));

/* dv/icec_top_tb.sv */
// Self-checking bench of the input capture control block
`timescale 1ns/1ps
`include "icec_defs.svh"
module icec_top_tb;
	import icec_pkg::*;
	logic         clk_i = 1'b0;
	logic         rst_n_i = 1'b0;
	icec_wb_req_t req = '0;
	logic [2:0]   lvl = 3'b000;
	logic [2:0]   pin;
	logic [31:0]  dat;
	logic         ack;
	logic         irq;
	logic [31:0]  seed = 32'h2fac;
	logic [7:0]   q;
	logic [2:0]   en;
	int           fail_count = 0;
	int           comparisons = 0;
	int           code;
	logic         ce = 1'b1;
	logic [2:0]   ev;
	int           ev_cnt = 0;
	int           exp_ev = 0;
	int           n;
	always #4 clk_i = ~clk_i;
	icec_pin_model i_icec_pin_model (.clk_i(clk_i), .lvl_i(lvl), .pin_o(pin));
	icec_top i_icec_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .wb_req_i(req), .wb_dat_o(dat),
		.wb_ack_o(ack), .cap_pin_i(pin), .cap_event_o(ev), .irq_o(irq));
	// Count event pulses seen on the outputs
	always @(posedge clk_i) begin
		if (rst_n_i) ev_cnt <= ev_cnt + $countones(ev);
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Edge model: does code fire on a rise or a fall
	function automatic logic [7:0] hit(input int c, input int rise);
		return (c == 2 || c == rise) ? 8'h07 : 8'h00;
	endfunction
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Classic single cycle, released at the ack edge
	task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
		int i;
		@(posedge clk_i);
		req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'h1, dat: {24'h0, d}};
		for (i = 0; i < 16; i++) begin
			@(posedge clk_i);
			if (ack === 1'b1) break;
		end
		q = dat[7:0];
		req <= '0;
		if (i == 16) begin
			chk(8'h00, 8'hff);
			end_sim;
		end
	endtask
	task automatic pins(input logic [2:0] v, input int n);
		@(posedge clk_i);
		lvl <= v;
		repeat (n) @(posedge clk_i);
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		bus(0, `ICEC_ADR_EDGE, 0);
		chk(q, 8'h00);
		bus(0, 12'h3fc, 0);
		chk(q, 8'h00);
		bus(1, `ICEC_ADR_ENFLAG, 8'h70);
		// Every edge code on a rise and a fall
		for (code = 0; code < 4; code++) begin
			bus(1, `ICEC_ADR_EDGE, {2'b00, {3{code[1:0]}}});
			bus(1, `ICEC_ADR_ENFLAG, 8'h70);
			pins(3'b111, 12);
			bus(1, `ICEC_ADR_ENFLAG, 8'h77);
			bus(0, `ICEC_ADR_ENFLAG, 0);
			chk(q, 8'h70 | hit(code, 1));
			bus(1, `ICEC_ADR_ENFLAG, 8'h70);
			pins(3'b000, 12);
			bus(0, `ICEC_ADR_ENFLAG, 0);
			chk(q, 8'h70 | hit(code, 0));
			exp_ev += $countones(hit(code, 1)) + $countones(hit(code, 0));
		end
		// Random enables: disabled channels stay quiet
		bus(1, `ICEC_ADR_EDGE, 8'h15);
		repeat (4) begin
			seed = lfsr(seed);
			en = seed[2:0];
			bus(1, `ICEC_ADR_ENFLAG, {1'b0, en, 4'h0});
			pins(3'b111, 12);
			bus(0, `ICEC_ADR_ENFLAG, 0);
			chk(q, {1'b0, en, 1'b0, en});
			exp_ev += $countones(en);
			pins(3'b000, 12);
		end
		// Filter drops a three cycle pulse, passes a long one
		bus(1, `ICEC_ADR_FILT, 8'h70);
		bus(0, `ICEC_ADR_FILT, 0);
		chk(q, 8'h70);
		bus(1, `ICEC_ADR_ENFLAG, 8'h70);
		pins(3'b111, 2);
		pins(3'b000, 12);
		bus(0, `ICEC_ADR_ENFLAG, 0);
		chk(q, 8'h70);
		pins(3'b111, 12);
		bus(0, `ICEC_ADR_ENFLAG, 0);
		chk(q, 8'h77);
		exp_ev += 3;
		// Interrupt masked, raised, cleared
		chk({7'h0, irq}, 8'h00);
		bus(1, `ICEC_ADR_IMASK, 8'h07);
		repeat (2) @(posedge clk_i);
		chk({7'h0, irq}, 8'h01);
		bus(1, `ICEC_ADR_ISTAT, 8'h07);
		repeat (2) @(posedge clk_i);
		chk({7'h0, irq}, 8'h00);
		bus(0, `ICEC_ADR_ENFLAG, 0);
		chk(q, 8'h77);
		// Clock enable low freezes the capture path
		bus(1, `ICEC_ADR_EDGE, 8'h00);
		bus(1, `ICEC_ADR_ENFLAG, 8'h70);
		n = ev_cnt;
		@(posedge clk_i);
		ce <= 1'b0;
		pins(3'b000, 12);
		chk(8'(ev_cnt - n), 8'h00);
		chk({7'h0, irq}, 8'h00);
		@(posedge clk_i);
		ce <= 1'b1;
		repeat (12) @(posedge clk_i);
		bus(0, `ICEC_ADR_ENFLAG, 0);
		chk(q, 8'h77);
		chk({7'h0, irq}, 8'h01);
		exp_ev += 3;
		chk(8'(ev_cnt), 8'(exp_ev));
		end_sim;
	end
endmodule // icec_top_tb
